// >>> selftest_base_regs.sv
// Purpose: Self-test result code and control block base address registers
// Assumes: Firmware reports test results and bug checks as one-cycle events
// Notes:   Reads return data one cycle after the select
//          A halted port stays halted until the next reset
`timescale 1ns/1ps
module selftest_base_regs (
	input  wire logic                              core_clk,
	input  wire logic                              rst_b,
	input  wire logic                              host_wr,
	input  wire logic [1:0]                        host_sel,
	input  wire logic [15:0]                       host_wdata,
	input  wire logic                              done_clear,
	output logic [15:0]                            host_rdata,
	input  wire selftest_base_pkg::test_result_s   test_result,
	input  wire selftest_base_pkg::bug_event_s     bug_event,
	input  wire logic                              unexp_int,
	output logic [17:0]                            control_block_base_addr,
	output logic [3:0]                             port_state,
	output logic                                   command_done_flag,
	output logic                                   network_side_halt,
	output logic                                   host_side_halt,
	output logic [1:0]                             led_out
);
	import selftest_base_pkg::*;

	state_s r_ff;
	state_s nxt_r;

	// Everything the block remembers lives in r_ff; the single comb
	// process works out nxt_r from it. Host writes, firmware events
	// and the read path are resolved in that one place so that their
	// priority reads top to bottom. Reset comes last and beats all.

	// ==========================================================
	// Bug check cause to result code
	function automatic logic [5:0] bug_code(
		input logic [2:0] cause,
		input logic       boot
	);
		logic [5:0] c;
		c = CODE_RESTART;
		case (cause)
			CAUSE_UNEXP_INT: c = CODE_UNEXP_INT;
			CAUSE_PARITY:    c = CODE_PARITY;
			CAUSE_XMT_ALLOC: c = boot ? CODE_XMT_BOOT : CODE_XMT_ALLOC;
			default:         c = CODE_RESTART;
		endcase
		return c;
	endfunction

	// ==========================================================
	// Status word view
	// Spare positions are tied to zero here so that they cannot
	// pick up stray state when the struct grows
	function automatic logic [15:0] status_word(
		input logic [5:0] code,
		input logic [3:0] state
	);
		logic [15:0] w;
		w = '0;
		w[CODE_LSB +: CODE_W]   = code;
		w[STATE_LSB +: STATE_W] = state;
		return w;
	endfunction

	// ==========================================================
	// Command and status view
	function automatic logic [15:0] cmd_word(
		input logic done
	);
		logic [15:0] w;
		w = '0;
		w[CMD_DONE_BIT] = done;
		return w;
	endfunction

	// ==========================================================
	// High base view; only the two address bits exist
	function automatic logic [15:0] high_word(
		input logic [1:0] high
	);
		logic [15:0] w;
		w = '0;
		w[HIGH_BITS-1:0] = high;
		return w;
	endfunction

	// ==========================================================
	// Read mux
	function automatic logic [15:0] read_word(
		input logic [1:0] sel,
		input state_s     r
	);
		logic [15:0] w;
		w = '0;
		if (sel == REG_STATUS) begin
			w = status_word(r.code, r.state);
		end else if (sel == REG_CMD_STATUS) begin
			w = cmd_word(r.done);
		end else if (sel == REG_BASE_LOW) begin
			w = r.base_low;
		end else begin
			w = high_word(r.base_high);
		end
		return w;
	endfunction

	// ==========================================================
	// Control block fetch address
	// The low register keeps bit 0 as written so the host reads back
	// its own value; only the fetch side forces it even
	function automatic logic [17:0] fetch_addr(
		input logic [1:0]  high,
		input logic [15:0] low
	);
		logic [17:0] a;
		a    = {high, low};
		a[0] = 1'b0;
		return a;
	endfunction

	always_comb begin
		logic pass_ok;
		// A pass is refused while an unexpected interrupt is pending
		pass_ok = test_result.pass && !(r_ff.unexp || unexp_int);
		nxt_r = r_ff;
		if (r_ff.timer != '0) begin
			nxt_r.timer = r_ff.timer - 32'd1;
		end
		// ==========================================================
		// Host writes
		if (host_wr) begin
			if (host_sel == REG_BASE_LOW) begin
				nxt_r.base_low = host_wdata;
			end else if (host_sel == REG_BASE_HIGH) begin
				nxt_r.base_high = host_wdata[HIGH_BITS-1:0];
			end
		end
		if (done_clear) begin
			nxt_r.done = 1'b0;
		end
		if (unexp_int && r_ff.phase == PH_TEST) begin
			nxt_r.unexp = 1'b1;
		end
		// ==========================================================
		// Self-test and bug check sequencing
		case (r_ff.phase)
			PH_TEST: begin
				if (test_result.valid) begin
					if (pass_ok) begin
						nxt_r.code  = CODE_PASS;
						nxt_r.state = ST_READY;
						nxt_r.done  = 1'b1;
						nxt_r.phase = PH_RUN;
					end else if (!test_result.pass) begin
						nxt_r.code  = test_result.code;
						nxt_r.phase = PH_HALT;
					end
				end else if (r_ff.timer == '0 && r_ff.unexp) begin
					nxt_r.phase = PH_BLINK;
					nxt_r.leds  = LED_FIRST;
					nxt_r.timer = 32'(LED_TOGGLE_CYC);
				end
			end
			PH_RUN: begin
				if (bug_event.valid) begin
					nxt_r.code      = bug_code(bug_event.cause, bug_event.boot);
					nxt_r.state     = ST_BOTH_HALTED;
					nxt_r.halt_net  = 1'b1;
					nxt_r.halt_host = 1'b1;
					nxt_r.phase     = PH_HALT;
				end
			end
			PH_BLINK: begin
				if (r_ff.timer == '0) begin
					nxt_r.leds  = ~r_ff.leds;
					nxt_r.timer = 32'(LED_TOGGLE_CYC);
				end
			end
			PH_HALT: begin
				// Results and bug events are refused until reset
			end
			default: begin
			end
		endcase
		// ==========================================================
		// Host reads; reserved bits read zero
		nxt_r.rdata = read_word(host_sel, r_ff);
		// Done set wins over a same-cycle host clear
		if (r_ff.phase == PH_TEST && nxt_r.phase == PH_RUN) begin
			nxt_r.done = 1'b1;
		end
		if (!rst_b) begin
			nxt_r       = '0;
			nxt_r.phase = PH_TEST;
			nxt_r.state = ST_RESET;
			nxt_r.timer = 32'(SELFTEST_CYC);
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge core_clk) begin
		r_ff <= nxt_r;
	end

	// ==========================================================
	// Outputs, all taken from r_ff
	// Bit 0 dropped so the fetch address is always even
	assign control_block_base_addr = fetch_addr(r_ff.base_high, r_ff.base_low);
	assign host_rdata        = r_ff.rdata;
	assign port_state        = r_ff.state;
	assign command_done_flag = r_ff.done;
	assign network_side_halt = r_ff.halt_net;
	assign host_side_halt    = r_ff.halt_host;
	assign led_out           = r_ff.leds;
endmodule

// >>> selftest_base_pkg.sv
// Purpose: Constants and types for the self-test result and control block base registers
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes:   Register selects are word indices on the host register port
//
// Summary of operation
// - Six-bit self-test result sits in bits 13..8 of the port status word, device-written.
// - Passing self-test leaves code zero, enters ready state 2, sets command-done flag.
// - Failing hardware test loads its own nonzero code; 1111xx/1101xx hardware, lower loopback.
// - Bug check halts network and host sides; codes 1 to 4 name the cause.
// - Transmit buffer allocation error during boot reports code 101001 instead.
// - Unexpected interrupt in self-test shows alternating LEDs after self-test time.
// - Low register holds base address bits 15..0; host writes, device reads.
// - Device ignores bit 0 of the low register, base is always even.
// - High register bits 1..0 hold address bits 17..16; bits 15..2 read zero.
package selftest_base_pkg;
	// ==========================================================
	// Register selects
	localparam logic [1:0] REG_CMD_STATUS = 2'h0;
	localparam logic [1:0] REG_STATUS     = 2'h1;
	localparam logic [1:0] REG_BASE_LOW   = 2'h2;
	localparam logic [1:0] REG_BASE_HIGH  = 2'h3;

	// ==========================================================
	// Field layout
	localparam int CODE_LSB      = 8;
	localparam int CMD_DONE_BIT  = 11;
	localparam int HIGH_BITS     = 2;
	localparam int STATE_LSB     = 0;
	localparam int CODE_W        = 6;
	localparam int STATE_W       = 4;

	// ==========================================================
	// States and codes
	localparam logic [3:0] ST_RESET   = 4'h0;
	localparam logic [3:0] ST_READY   = 4'h2;
	localparam logic [3:0] ST_BOTH_HALTED = 4'h7;
	localparam logic [5:0] CODE_PASS       = 6'h00;
	localparam logic [5:0] CODE_RESTART    = 6'h01;
	localparam logic [5:0] CODE_UNEXP_INT  = 6'h02;
	localparam logic [5:0] CODE_PARITY     = 6'h03;
	localparam logic [5:0] CODE_XMT_ALLOC  = 6'h04;
	localparam logic [5:0] CODE_XMT_BOOT   = 6'h29;
	localparam logic [2:0] CAUSE_RESTART   = 3'h1;
	localparam logic [2:0] CAUSE_UNEXP_INT = 3'h2;
	localparam logic [2:0] CAUSE_PARITY    = 3'h3;
	localparam logic [2:0] CAUSE_XMT_ALLOC = 3'h4;
	localparam logic [1:0] LED_FIRST       = 2'h1;

	// ==========================================================
	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int SELFTEST_MS   = 1;
	localparam int SELFTEST_CYC  = CLK_HZ / 1000 * SELFTEST_MS;
	localparam int LED_TOGGLE_CYC = 1_000;

	typedef enum logic [1:0] {
		PH_TEST,
		PH_RUN,
		PH_HALT,
		PH_BLINK
	} phase_e;

	typedef struct packed {
		logic        valid;
		logic        pass;
		logic [5:0]  code;
	} test_result_s;

	typedef struct packed {
		logic        valid;
		logic        boot;
		logic [2:0]  cause;
	} bug_event_s;

	typedef struct packed {
		phase_e      phase;
		logic [5:0]  code;
		logic [3:0]  state;
		logic        done;
		logic [15:0] base_low;
		logic [1:0]  base_high;
		logic [15:0] rdata;
		logic [1:0]  leds;
		logic        unexp;
		logic [31:0] timer;
		logic        halt_net;
		logic        halt_host;
	} state_s;
endpackage

// >>> selftest_base_props.sv
// Purpose: Port checks for result code and base address registers
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
module selftest_base_props (
	input wire logic                            core_clk,
	input wire logic                            rst_b,
	input wire logic                            host_wr,
	input wire logic [1:0]                      host_sel,
	input wire logic [15:0]                     host_wdata,
	input wire logic [15:0]                     host_rdata,
	input wire selftest_base_pkg::test_result_s test_result,
	input wire selftest_base_pkg::bug_event_s   bug_event,
	input wire logic                            unexp_int,
	input wire logic [17:0]                     control_block_base_addr,
	input wire logic [3:0]                      port_state,
	input wire logic                            command_done_flag,
	input wire logic                            network_side_halt,
	input wire logic                            host_side_halt,
	input wire logic [1:0]                      led_out
);
	import selftest_base_pkg::*;
	// ==========================================================
	// Helper: self-test still open, unexpected interrupt seen in it
	logic test_open_ff;
	logic unexp_seen_ff;
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			test_open_ff  <= 1'b1;
			unexp_seen_ff <= 1'b0;
		end else begin
			if (test_result.valid) begin
				test_open_ff <= 1'b0;
			end
			if (unexp_int && test_open_ff) begin
				unexp_seen_ff <= 1'b1;
			end
		end
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_code_rd; host_sel == REG_STATUS |=> host_rdata[15:14] == 2'h0 && host_rdata[7:4] == 4'h0; endproperty
	a_code_rd: assert property (p_code_rd) else $error("status word spare bits set");
	property p_ready; test_result.valid && test_result.pass && test_open_ff && !unexp_seen_ff && !unexp_int
		|=> port_state == ST_READY && command_done_flag; endproperty
	a_ready: assert property (p_ready) else $error("ready not entered");
	property p_halt; bug_event.valid && port_state == ST_READY
		|=> network_side_halt && host_side_halt && port_state == ST_BOTH_HALTED; endproperty
	a_halt: assert property (p_halt) else $error("bug check did not halt");
	property p_low; host_wr && host_sel == REG_BASE_LOW |=> control_block_base_addr[15:1] == $past(host_wdata[15:1]); endproperty
	a_low: assert property (p_low) else $error("low base not taken");
	property p_even; control_block_base_addr[0] == 1'b0; endproperty
	a_even: assert property (p_even) else $error("base address odd");
	property p_high; host_wr && host_sel == REG_BASE_HIGH |=> control_block_base_addr[17:16] == $past(host_wdata[1:0]); endproperty
	a_high: assert property (p_high) else $error("high base not taken");
	property p_hi_rd; host_sel == REG_BASE_HIGH |=> host_rdata[15:2] == 14'h0; endproperty
	a_hi_rd: assert property (p_hi_rd) else $error("high base spare bits set");
	property p_stable; !host_wr |=> $stable(control_block_base_addr); endproperty
	a_stable: assert property (p_stable) else $error("base changed without write");
	property p_refuse; test_result.valid && test_result.pass && test_open_ff && (unexp_seen_ff || unexp_int)
		|=> port_state == ST_RESET && !command_done_flag; endproperty
	a_refuse: assert property (p_refuse) else $error("pass taken despite unexpected interrupt");
	property p_blink; led_out != 2'h0
		|=> led_out != 2'h0 && led_out != 2'h3 && (led_out == $past(led_out) || led_out == ~$past(led_out)); endproperty
	a_blink: assert property (p_blink) else $error("indicator pattern not alternating");
endmodule
bind selftest_base_regs selftest_base_props u_props (.*);

// >>> host_port_drv.sv
// Purpose: Host port driver model issuing register accesses
// Assumes: Reads answer one cycle after the select
// Notes:   Clear strobe pulses for one cycle per clear
`timescale 1ns/1ps
module host_port_drv (
	input  wire logic        core_clk,
	input  wire logic [15:0] host_rdata,
	output logic             host_wr,
	output logic [1:0]       host_sel,
	output logic [15:0]      host_wdata,
	output logic             done_clear
);
	initial begin
		host_wr = 1'b0;
		host_sel = 2'h0;
		host_wdata = 16'h0;
		done_clear = 1'b0;
	end
	task automatic wr(input logic [1:0] s, input logic [15:0] v);
		@(posedge core_clk);
		host_wr <= 1'b1;
		host_sel <= s;
		host_wdata <= v;
		@(posedge core_clk);
		host_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] s, output logic [15:0] v);
		@(posedge core_clk);
		host_sel <= s;
		repeat (2) @(posedge core_clk);
		v = host_rdata;
	endtask
	task automatic clr;
		@(posedge core_clk);
		done_clear <= 1'b1;
		@(posedge core_clk);
		done_clear <= 1'b0;
	endtask
endmodule

// >>> selftest_code_and_block_base_regs_tb.sv
// Purpose: Directed bench for result code and base registers
// Assumes: Events are one-cycle pulses
// Notes:   Second reset reopens the self-test phase
`timescale 1ns/1ps
module selftest_code_and_block_base_regs_tb;
	import selftest_base_pkg::*;
	logic         core_clk, rst_b, host_wr, done_clear, unexp_int;
	logic [1:0]   host_sel, led_out;
	logic [15:0]  host_wdata, host_rdata, d;
	test_result_s test_result;
	bug_event_s   bug_event;
	logic [17:0]  control_block_base_addr;
	logic [3:0]   port_state;
	logic         command_done_flag, network_side_halt, host_side_halt;
	int           fails, n_tests, cyc;
	selftest_base_regs DUT (.*);
	host_port_drv host (.*);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// ==========================================================
	// Tasks
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
	endtask
	task automatic ev(input test_result_s t, input bug_event_s b);
		@(posedge core_clk);
		test_result <= t;
		bug_event <= b;
		@(posedge core_clk);
		test_result <= '0;
		bug_event <= '0;
		repeat (2) @(posedge core_clk);
	endtask
	task automatic t_pass;
		ev('{1'b1, 1'b1, CODE_PASS}, '0);
		chk(port_state, ST_READY);
		chk(command_done_flag, 1'b1);
		host.rd(REG_STATUS, d);
		chk(d[13:8], CODE_PASS);
		host.rd(REG_CMD_STATUS, d);
		chk(d[CMD_DONE_BIT], 1'b1);
		host.clr();
		@(posedge core_clk);
		chk(command_done_flag, 1'b0);
		$display("pass test done");
	endtask
	task automatic t_base;
		host.wr(REG_BASE_LOW, 16'h1235);
		host.wr(REG_BASE_HIGH, 16'hFFFF);
		@(posedge core_clk);
		chk(control_block_base_addr, 18'h31234);
		host.rd(REG_BASE_HIGH, d);
		chk(d, 16'h0003);
		host.rd(REG_BASE_LOW, d);
		chk(d, 16'h1235);
		$display("base test done");
	endtask
	task automatic t_boot;
		ev('0, '{1'b1, 1'b1, 3'h4});
		chk({network_side_halt, host_side_halt}, 2'h3);
		host.rd(REG_STATUS, d);
		chk(d[13:8], CODE_XMT_BOOT);
		chk(d[3:0], ST_BOTH_HALTED);
		for (int c = 1; c <= 4; c++) begin
			do_reset();
			ev('{1'b1, 1'b1, CODE_PASS}, '0);
			ev('0, '{1'b1, 1'b0, 3'(c)});
			host.rd(REG_STATUS, d);
			chk(d[13:8], 6'(c));
		end
		$display("boot bug test done");
	endtask
	task automatic t_fail;
		do_reset();
		ev('{1'b1, 1'b0, 6'h3E}, '0);
		host.rd(REG_STATUS, d);
		chk(d[13:8], 6'h3E);
		$display("fail test done");
	endtask
	task automatic t_blink;
		do_reset();
		@(posedge core_clk);
		unexp_int <= 1'b1;
		@(posedge core_clk);
		unexp_int <= 1'b0;
		ev('{1'b1, 1'b1, CODE_PASS}, '0);
		chk(port_state, ST_RESET);
		chk(command_done_flag, 1'b0);
		chk(led_out, 2'h0);
		repeat (SELFTEST_CYC) @(posedge core_clk);
		chk(led_out, 2'h1);
		repeat (LED_TOGGLE_CYC) @(posedge core_clk);
		chk(led_out, 2'h2);
		$display("blink test done");
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 15000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		rst_b = 1'b0;
		unexp_int = 1'b0;
		test_result = '0;
		bug_event = '0;
		do_reset();
		t_pass();
		t_base();
		t_boot();
		t_fail();
		t_blink();
		conclude();
	end
endmodule
